// ==== src/apt_pkg.sv ====
package apt_pkg;

  // Register bus geometry
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_MODE = 2'h0;
  localparam logic [ADDR_W-1:0] OFF_SEL = 2'h1;
  localparam logic [ADDR_W-1:0] OFF_STAT = 2'h2;

  // Reset values
  localparam logic [DATA_W-1:0] MODE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] SEL_RESET = 8'h00;

  // Converter mode register fields
  localparam int MODE_BOOST_BIT = 0;
  localparam int MODE_HS_BIT = 1;
  localparam int MODE_SCAN_BIT = 2;
  localparam int MODE_CONV_BIT = 7;
  localparam logic [DATA_W-1:0] MODE_WMASK = 8'h87;

  // Input-select register fields
  localparam int SEL_CH_LSB = 0;
  localparam int SEL_CH_W = 3;
  localparam int SEL_ZERO_BIT = 3;
  localparam int SEL_SRC_BIT = 4;
  localparam int SEL_TRG_BIT = 5;
  localparam int SEL_EDGE_LSB = 6;
  localparam logic [DATA_W-1:0] SEL_WMASK = 8'hF7;

  // Status register fields
  localparam int STAT_GEN_BIT = 0;
  localparam int STAT_READY_BIT = 1;
  localparam int STAT_AUTO_BIT = 2;
  localparam int STAT_DISCARD_BIT = 3;

  // Edge select encodings
  typedef enum logic [1:0] {
    APT_EDGE_NONE = 2'h0,
    APT_EDGE_FALL = 2'h1,
    APT_EDGE_RISE = 2'h2,
    APT_EDGE_BOTH = 2'h3
  } apt_edge_e;

  // Setup timing of the converter after boost power-up
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETUP_HS_NS = 1000;
  localparam int SETUP_NORM_NS = 14000;
  localparam int SETUP_HS_CYC = (SETUP_HS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_NORM_CYC = (SETUP_NORM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Boost generator sequencing states, Gray along the power-up path
  typedef enum logic [1:0] {
    APT_GEN_OFF = 2'b00,
    APT_GEN_SETTLE = 2'b01,
    APT_GEN_READY = 2'b11
  } apt_gen_e;

endpackage

// ==== src/apt_edge_detect.sv ====
`timescale 1ns/1ps
`default_nettype none
module apt_edge_detect (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic pin_in,
  input wire logic [1:0] edge_sel_in,
  output logic edge_out
);
  import apt_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic edge_p;
  } apt_edge_s;

  apt_edge_s q, d;

  // Accept a level once the last two stages agree, then flag the chosen edges
  always_comb begin
    d = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.edge_p = 1'b0;
    if (q.s2 == q.s3) begin
      d.level = q.s2;
      unique case (apt_edge_e'(edge_sel_in))
        APT_EDGE_NONE: d.edge_p = 1'b0;
        APT_EDGE_FALL: d.edge_p = q.level && !q.s2;
        APT_EDGE_RISE: d.edge_p = !q.level && q.s2;
        APT_EDGE_BOTH: d.edge_p = q.level != q.s2;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign edge_out = q.edge_p;
endmodule
`default_nettype wire

// ==== src/apt_setup_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module apt_setup_timer #(
  parameter int CNT_W = 11
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic run_in,
  input wire logic high_speed_in,
  output logic ready_out
);
  import apt_pkg::*;

  // Refuse a counter too narrow for the longer setup wait
  if (SETUP_NORM_CYC >= (1 << CNT_W) || SETUP_HS_CYC >= (1 << CNT_W)) begin : g_bad_width
    $error("apt_setup_timer: CNT_W too small for setup count");
  end

  localparam logic [CNT_W-1:0] HS_LAST = CNT_W'(SETUP_HS_CYC - 1);
  localparam logic [CNT_W-1:0] NORM_LAST = CNT_W'(SETUP_NORM_CYC - 1);

  typedef struct packed {
    apt_gen_e state;
    logic [CNT_W-1:0] cnt;
    logic ready;
  } apt_timer_s;

  apt_timer_s q, d;
  logic [CNT_W-1:0] last;

  // Count the setup wait from generator power-up; drop at once on power-off
  always_comb begin
    d = q;
    last = high_speed_in ? HS_LAST : NORM_LAST;
    if (!run_in) begin
      d.state = APT_GEN_OFF;
      d.cnt = '0;
    end else begin
      unique case (q.state)
        APT_GEN_OFF: begin
          d.state = APT_GEN_SETTLE;
          d.cnt = '0;
        end
        APT_GEN_SETTLE: begin
          if (q.cnt >= last) begin
            d.state = APT_GEN_READY;
          end else begin
            d.cnt = q.cnt + 1'b1;
          end
        end
        APT_GEN_READY: d.state = APT_GEN_READY;
        default: d.state = APT_GEN_OFF;
      endcase
    end
    d.ready = (d.state == APT_GEN_READY);
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q <= '{state: APT_GEN_OFF, cnt: '0, ready: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign ready_out = q.ready;
endmodule
`default_nettype wire

// ==== src/apt_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module apt_control (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [apt_pkg::ADDR_W-1:0] addr_in,
  input wire logic [apt_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  output logic [apt_pkg::DATA_W-1:0] rd_data_out,
  input wire logic ext_trigger_pin_in,
  input wire logic timer_match_event_in,
  output logic boost_gen_on_out,
  output logic conv_power_out,
  output logic conv_active_out,
  output logic setup_ready_out,
  output logic conv_start_out,
  output logic start_usable_out,
  output logic [2:0] channel_out,
  output logic [7:0] channel_mask_out
);
  import apt_pkg::*;

  localparam int NUM_CH = 1 << SEL_CH_W;

  typedef struct packed {
    logic [DATA_W-1:0] converter_mode_reg;
    logic [DATA_W-1:0] input_select_trigger;
    logic [DATA_W-1:0] rd_data;
    logic auto_on;
    logic discard;
    logic gen_on;
    logic start;
    logic usable;
    logic [NUM_CH-1:0] mask;
  } apt_ctrl_s;

  apt_ctrl_s q, d;

  logic ext_edge;
  logic setup_ready;
  logic [NUM_CH-1:0] mask_w;
  logic wr_mode, wr_sel;
  logic conv_run_enable, ref_boost_enable;
  logic prev_conv, prev_boost;
  logic trigger_mode_select, hw_trigger_source;
  logic hw_trigger, sw_trigger, gen_req;
  logic [SEL_CH_W-1:0] chan;
  logic [DATA_W-1:0] sel_next;
  logic [DATA_W-1:0] mode_next;

  // Field views of the stored registers, except chan, which views the next select value sel_next
  assign trigger_mode_select = q.input_select_trigger[SEL_TRG_BIT];
  assign hw_trigger_source = q.input_select_trigger[SEL_SRC_BIT];
  assign chan = sel_next[SEL_CH_LSB +: SEL_CH_W];
  assign prev_conv = q.converter_mode_reg[MODE_CONV_BIT];
  assign prev_boost = q.converter_mode_reg[MODE_BOOST_BIT];

  // External pin edges, synchronised inside
  apt_edge_detect u_edge (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in(ext_trigger_pin_in),
    .edge_sel_in(q.input_select_trigger[SEL_EDGE_LSB +: 2]),
    .edge_out(ext_edge)
  );

  // Setup wait after generator power-up
  apt_setup_timer u_timer (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .run_in(q.gen_on),
    .high_speed_in(q.converter_mode_reg[MODE_HS_BIT]),
    .ready_out(setup_ready)
  );

  // Register contents as they stand after this edge, so the mask moves with the channel field
  assign sel_next = (wr_strobe_in && (addr_in == OFF_SEL))
                    ? (wr_data_in & SEL_WMASK) : q.input_select_trigger;
  assign mode_next = (wr_strobe_in && (addr_in == OFF_MODE))
                     ? (wr_data_in & MODE_WMASK) : q.converter_mode_reg;

  // Channel selection mask, one term per analog input
  for (genvar i = 0; i < NUM_CH; i++) begin : g_mask
    assign mask_w[i] = mode_next[MODE_SCAN_BIT]
                       ? (SEL_CH_W'(i) <= chan) : (SEL_CH_W'(i) == chan);
  end

  // Hardware trigger source choice
  assign hw_trigger = hw_trigger_source ? timer_match_event_in : ext_edge;

  // Next-state logic
  always_comb begin
    d = q;
    d.start = 1'b0;
    d.rd_data = '0;
    wr_mode = wr_strobe_in && (addr_in == OFF_MODE);
    wr_sel = wr_strobe_in && (addr_in == OFF_SEL);

    // Register writes
    if (wr_mode) begin
      d.converter_mode_reg = wr_data_in & MODE_WMASK;
    end
    if (wr_sel) begin
      d.input_select_trigger = wr_data_in & SEL_WMASK;
    end
    conv_run_enable = d.converter_mode_reg[MODE_CONV_BIT];
    ref_boost_enable = d.converter_mode_reg[MODE_BOOST_BIT];

    // Automatic generator power-up from the fully stopped state
    if (!prev_conv && !prev_boost && conv_run_enable) begin
      d.auto_on = 1'b1;
    end
    if (!conv_run_enable) begin
      d.auto_on = 1'b0;
    end

    // Generator and converter power follow the boost bit or the auto hold
    gen_req = ref_boost_enable || d.auto_on;
    d.gen_on = gen_req;

    // A fresh auto power-up in software mode spoils the first result
    if (d.auto_on && !q.auto_on && !trigger_mode_select) begin
      d.discard = 1'b1;
    end
    if (!gen_req) begin
      d.discard = 1'b0;
    end

    // Conversion start: software by enabling, hardware by the chosen event
    sw_trigger = wr_mode && conv_run_enable;
    if (!trigger_mode_select) begin
      if (sw_trigger) begin
        d.start = 1'b1;
        d.usable = setup_ready && !d.discard;
        d.discard = 1'b0;
      end
    end else if (prev_conv && conv_run_enable && hw_trigger) begin // No start as enable drops
      d.start = 1'b1;
      d.usable = setup_ready;
    end

    d.mask = mask_w;

    // Read data, present only in the cycle after the strobe
    if (rd_strobe_in) begin
      unique case (addr_in)
        OFF_MODE: d.rd_data = q.converter_mode_reg;
        OFF_SEL: d.rd_data = q.input_select_trigger;
        OFF_STAT: begin
          d.rd_data[STAT_GEN_BIT] = q.gen_on;
          d.rd_data[STAT_READY_BIT] = setup_ready;
          d.rd_data[STAT_AUTO_BIT] = q.auto_on;
          d.rd_data[STAT_DISCARD_BIT] = q.discard;
        end
        default: d.rd_data = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q <= '0;
      q.converter_mode_reg <= MODE_RESET;
      q.input_select_trigger <= SEL_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs, all from flip-flops
  assign rd_data_out = q.rd_data;
  assign boost_gen_on_out = q.gen_on;
  assign conv_power_out = q.gen_on;
  assign conv_active_out = q.converter_mode_reg[MODE_CONV_BIT];
  assign setup_ready_out = setup_ready;
  assign conv_start_out = q.start;
  assign start_usable_out = q.usable;
  assign channel_out = q.input_select_trigger[SEL_CH_LSB +: SEL_CH_W];
  assign channel_mask_out = q.mask;
endmodule
`default_nettype wire

// ==== verif/apt_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module apt_assertions (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_strobe_in,
  input wire logic rd_strobe_in,
  input wire logic [7:0] rd_data_out,
  input wire logic boost_gen_on_out,
  input wire logic conv_power_out,
  input wire logic conv_active_out,
  input wire logic setup_ready_out,
  input wire logic conv_start_out,
  input wire logic [2:0] channel_out,
  input wire logic [7:0] channel_mask_out
);
  logic [2:0] ch_q;
  // Last written channel field candidate
  always_ff @(posedge clk_in) begin
    ch_q <= wr_data_in[2:0];
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  AST_PWR_SAME: assert property (conv_power_out == boost_gen_on_out)
    else $error("converter power differs from generator");
  AST_BOTH_OFF: assert property (wr_strobe_in && addr_in == 2'h0 && wr_data_in[7] == 1'b0 && wr_data_in[0] == 1'b0 |=> !boost_gen_on_out && !conv_active_out)
    else $error("generator still on after stop");
  AST_AUTO_ON: assert property (wr_strobe_in && addr_in == 2'h0 && wr_data_in[7] && !conv_active_out && !boost_gen_on_out |=> boost_gen_on_out && conv_active_out)
    else $error("generator not switched on automatically");
  AST_BOOST_KEEP: assert property (wr_strobe_in && addr_in == 2'h0 && wr_data_in[0] |=> boost_gen_on_out)
    else $error("generator off with boost bit set");
  AST_SEL_BIT3: assert property ($past(rd_strobe_in) && $past(addr_in) == 2'h1 |-> !rd_data_out[3])
    else $error("select bit 3 read as one");
  AST_START_EN: assert property (conv_start_out |-> conv_active_out)
    else $error("start while conversion disabled");
  AST_SETUP: assert property ($rose(setup_ready_out) |-> boost_gen_on_out && $past(boost_gen_on_out, 99))
    else $error("setup ready too early");
  AST_CH_FOLLOW: assert property (wr_strobe_in && addr_in == 2'h1 |=> channel_out == ch_q)
    else $error("channel field not updated");
  AST_MASK: assert property (channel_mask_out != 8'h00 |-> (channel_mask_out >> channel_out) == 8'h01)
    else $error("channel mask does not end at channel");
endmodule
bind apt_control apt_assertions i_apt_assertions (.clk_in(clk_in), .reset_in(reset_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_strobe_in(wr_strobe_in),
  .rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out), .boost_gen_on_out(boost_gen_on_out),
  .conv_power_out(conv_power_out), .conv_active_out(conv_active_out),
  .setup_ready_out(setup_ready_out), .conv_start_out(conv_start_out),
  .channel_out(channel_out), .channel_mask_out(channel_mask_out));
`default_nettype wire

// ==== verif/apt_trig_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module apt_trig_model (
  input wire logic clk_in,
  output logic pin_out,
  output logic tmr_out
);
  // Idle levels
  initial begin
    pin_out = 1'b0;
    tmr_out = 1'b0;
  end
  // Timer match lasts exactly one clock
  task automatic pulse_timer;
    @(posedge clk_in);
    tmr_out <= 1'b1;
    @(posedge clk_in);
    tmr_out <= 1'b0;
  endtask
  // Pin level held long enough to pass the synchroniser
  task automatic set_pin(input logic l);
    @(posedge clk_in);
    pin_out <= l;
    repeat (10) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import apt_pkg::*;
  logic clk_in = 0, reset_in = 1, wst = 0, rst = 0, pin, tmr, gen, pwr, act, rdy, start, usable;
  logic [1:0] addr = 0;
  logic [7:0] wd = 0, rdv, rdo, mask, mode_m = 0, sel_m = 0;
  logic [7:0] seq[9] = '{8'h80, 8'h00, 8'h81, 8'h01, 8'h00, 8'h01, 8'h81, 8'h80, 8'h00};
  logic [2:0] ch;
  logic auto_m = 0;
  int error_cnt = 0, num_checks = 0, cyc = 0, starts = 0, v;
  apt_control i_dut (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr), .wr_data_in(wd),
    .wr_strobe_in(wst), .rd_strobe_in(rst), .rd_data_out(rdo), .ext_trigger_pin_in(pin),
    .timer_match_event_in(tmr), .boost_gen_on_out(gen), .conv_power_out(pwr),
    .conv_active_out(act), .setup_ready_out(rdy), .conv_start_out(start),
    .start_usable_out(usable), .channel_out(ch), .channel_mask_out(mask));
  apt_trig_model i_trig (.clk_in(clk_in), .pin_out(pin), .tmr_out(tmr));
  always #5 clk_in = ~clk_in;
  // Cycle count, start count and hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (start === 1'b1) starts <= starts + 1;
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Write cycle plus reference model update
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wd <= d;
    wst <= 1'b1;
    @(posedge clk_in);
    wst <= 1'b0;
    if (a == OFF_MODE) begin
      if (mode_m[7] == 0 && mode_m[0] == 0 && d[7]) auto_m = 1;
      if (!d[7]) auto_m = 0;
      mode_m = d & MODE_WMASK;
    end else if (a == OFF_SEL) sel_m = d & SEL_WMASK;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    rst <= 1'b1;
    @(posedge clk_in);
    rst <= 1'b0;
    #1 d = rdo;
  endtask
  // Mode write then power and start outputs against the model
  task automatic pair(input logic [7:0] d);
    logic g;
    logic [7:0] e;
    wr(OFF_MODE, d);
    g = mode_m[0] | auto_m;
    e = {4'h0, d[7], g, g, d[7] & ~sel_m[5]};
    #1 chk({4'h0, act, gen, pwr, start}, e, "pair");
  endtask
  function automatic logic [7:0] emask();
    int c;
    c = sel_m[2:0];
    return mode_m[2] ? 8'((1 << (c + 1)) - 1) : 8'(1 << c);
  endfunction
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    v = $urandom(32'h66CC);
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(OFF_SEL, rdv);
    chk(rdv, SEL_RESET, "sel reset");
    rd(OFF_MODE, rdv);
    chk(rdv, MODE_RESET, "mode reset");
    rd(2'h3, rdv);
    chk(rdv, 8'h00, "unmapped");
    for (int i = 0; i < 8; i++) begin
      wr(OFF_MODE, {5'h0, i[0], 2'h0});
      wr(OFF_SEL, 8'($urandom));
      rd(OFF_SEL, rdv);
      chk(rdv, sel_m, "sel read");
      chk({5'h0, ch}, {5'h0, sel_m[2:0]}, "channel");
      chk(mask, emask(), "mask");
    end
    wr(OFF_SEL, 8'h00);
    foreach (seq[k]) pair(seq[k]);
    wr(OFF_SEL, 8'h30);
    wr(OFF_MODE, 8'h03);
    v = 0;
    // Software waits for the setup time before enabling
    while (rdy !== 1'b1 && v < 300) begin
      @(negedge clk_in);
      v++;
    end
    chk(8'(v >= 100 && v < 300), 8'h01, "setup wait");
    rd(OFF_STAT, rdv);
    chk(rdv, 8'((1 << STAT_GEN_BIT) | (1 << STAT_READY_BIT)), "standby status");
    pair(8'h83);
    i_trig.pulse_timer();
    #1 chk({6'h0, start, usable}, 8'h03, "timer start");
    for (int e = 0; e < 4; e++) begin
      wr(OFF_SEL, {e[1:0], 6'h20});
      v = starts;
      i_trig.set_pin(1'b1);
      i_trig.set_pin(1'b0);
      chk(8'(starts - v), 8'(e == 3 ? 2 : e != 0), "pin edges");
    end
    wr(OFF_SEL, 8'h10);
    v = starts;
    i_trig.pulse_timer();
    repeat (3) @(posedge clk_in);
    chk(8'(starts - v), 8'h00, "sw mode timer");
    pair(8'h83);
    chk({7'h0, usable}, 8'h01, "sw start after setup wait");
    pair(8'h00);
    pair(8'h82);
    chk({7'h0, usable}, 8'h00, "first sw result after auto on");
    pair(8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
